// *** osc_ctrl_pkg.sv ***
// Register map, field positions, reset values and timing constants for the oscillator control block
package osc_ctrl_pkg;

  // Register byte offsets on the APB bus
  localparam logic [11:0] OFS_OSC_CONTROL  = 12'h000;
  localparam logic [11:0] OFS_CLOCK_DIV    = 12'h004;
  localparam logic [11:0] OFS_FAST_RC_TUNE = 12'h008;
  localparam logic [11:0] OFS_UNLOCK_KEY   = 12'h00C;

  // Oscillator control fields
  localparam int CUR_SEL_LSB      = 12;
  localparam int REQ_SEL_LSB      = 8;
  localparam int FREEZE_BIT       = 7;
  localparam int PLL_LOCK_BIT     = 5;
  localparam int FAIL_BIT         = 3;
  localparam int SEC_DRIVE_BIT    = 2;
  localparam int SEC_ENABLE_BIT   = 1;
  localparam int SWITCH_BIT       = 0;

  // Clock divider fields
  localparam int RECOVER_BIT      = 15;
  localparam int RATIO_LSB        = 12;
  localparam int RATIO_EN_BIT     = 11;
  localparam int POSTSCALE_LSB    = 8;

  // Reset values
  localparam logic [2:0] RATIO_RESET     = 3'h3;
  localparam logic [2:0] POSTSCALE_RESET = 3'h1;
  localparam logic [5:0] TRIM_RESET      = 6'h00;

  // Unlock keys written to the key register
  localparam logic [7:0] KEY_HI_FIRST  = 8'h78;
  localparam logic [7:0] KEY_HI_SECOND = 8'h9A;
  localparam logic [7:0] KEY_LO_FIRST  = 8'h46;
  localparam logic [7:0] KEY_LO_SECOND = 8'h57;

  // Source encodings
  localparam logic [2:0] SRC_FRC_DIV    = 3'h7;
  localparam logic [2:0] SRC_LPFRC_DIV  = 3'h6;
  localparam logic [2:0] SRC_LOW_POWER_RC_SOURCE       = 3'h5;
  localparam logic [2:0] SRC_SECONDARY  = 3'h4;
  localparam logic [2:0] SRC_PRIMARY_PL = 3'h3;
  localparam logic [2:0] SRC_PRIMARY    = 3'h2;
  localparam logic [2:0] SRC_FRC_PLL    = 3'h1;
  localparam logic [2:0] SRC_FRC        = 3'h0;

  // Primary submode encodings
  localparam logic [1:0] SUB_HS_XTAL  = 2'h2;
  localparam logic [1:0] SUB_STD_XTAL = 2'h1;
  localparam logic [1:0] SUB_EXT_CLK  = 2'h0;
  localparam logic [1:0] SUB_INTERNAL = 2'h3;

  // Settle time in new-source cycles before change-over
  localparam int SETTLE_CYCLES = 10;
  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);

endpackage

// *** ratio_divider.sv ***
// Power-of-two clock-enable divider used for doze and fast RC postscale
`timescale 1ns/1ns
`default_nettype none
module ratio_divider
  import osc_ctrl_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Divide select as a mask of low count bits
  input  wire logic [CNT_W-1:0] mask,
  // Tick high for one enabled (ce) cycle every divided period
  output logic                  tick
);
  // Counter width must be from 1 to 16 bits and stay small
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
    $error("ratio_divider: CNT_W out of range");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             tick_q;
  logic             tick_d;

  // Wrap when all masked bits are set; mask zero gives every cycle
  always_comb begin
    tick_d = ((cnt_q & mask) == mask);
    cnt_d  = tick_d ? '0 : cnt_q + CNT_W'(1);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// *** osc_ctrl.sv ***
// Oscillator selection, switch sequencing, doze ratio and fast RC postscale control
`timescale 1ns/1ns
`default_nettype none
//
// Behaviour
// (R1) Switching allowed only when switch/monitor config msb is zero.
// (R2) Fail-safe monitor enabled only when both config bits are zero.
// (R3) Primary submode: 10 high-speed crystal, 01 standard crystal, 00 external.
// (R4) Unprogrammed device starts from fast RC divided, code 111, submode 11.
// (R5) Read-only current source field at bits 14-12, hardware updated.
// (R6) Requested source field at bits 10-8; reset from initial source config.
// (R7) Writing one to bit 0 starts switch; hardware clears on completion.
// (R8) With monitor on, set-only freeze bit blocks switch requests.
// (R9) With monitor off, freeze bit never blocks switching.
// (R10) PLL lock bit 5 reads one when locked or timer expired; no timer here, only PLL_LOCKED sets it.
// (R11) Lock bit forced zero on valid switch start and non-PLL modes.
// (R12) Clock fail flag set by hardware, software may only clear.
// (R13) Secondary drive bit 2 selects high power; no effect on digital input.
// (R14) Secondary enable bit 1 turns the 32 kHz oscillator on.
// (R15) Recover-on-interrupt clears doze enable on any interrupt.
// (R16) Ratio field bits 14-12: 000 is 1:1 up to 111 is 1:128.
// (R17) Doze enable bit 11 applies ratio; clear forces 1:1.
// (R18) For sources 111/110 postscaler divides 1,2,4,8,16,32,64,256.
// (R19) Postscaler resets to 001, ratio resets to 011.
// (R20) Six-bit trim field in tune register, reset zero.
// (R21) Unimplemented bits ignore writes and read zero.
// (R22) Switch to current source is redundant: clear request, no change.
// (R23) Wait 10 new-source cycles once running and PLL-locked.
// (R24) On completion copy requested into current field, clear request.
// (R25) Keys 78h,9Ah unlock high byte; 46h,57h unlock low byte.
// (R26) CPU clock enable divides peripheral rate by ratio during doze.
// (R27) Switch requests ignored when switching disabled; request stays zero.
module osc_ctrl
  import osc_ctrl_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        CLK_EN,
  // Non-volatile configuration
  input  wire logic [1:0]  SWITCH_MONITOR_CFG,
  input  wire logic [1:0]  PRIMARY_SUBMODE_CFG,   // R3
  input  wire logic [2:0]  INITIAL_SOURCE_CFG,
  input  wire logic        SECONDARY_SOURCE_CFG,
  // Analogue status
  input  wire logic        NEW_SRC_READY,
  input  wire logic        NEW_SRC_TICK,
  input  wire logic        PLL_LOCKED,
  input  wire logic        CLOCK_FAIL_DET,
  input  wire logic        IRQ_EVENT,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Clock control outputs
  output logic [2:0]       ACTIVE_SOURCE,
  output logic [2:0]       TARGET_SOURCE,
  output logic             SWITCH_BUSY,
  output logic             FAIL_SAFE_ON,
  output logic             SECONDARY_OSC_ENABLE,
  output logic             SECONDARY_DRIVE_HIGH,
  output logic [5:0]       FAST_RC_TRIM,
  output logic             CPU_CLK_EN,
  output logic             SYS_CLK_EN
);

  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_WAIT   = 2'b01,
    SW_SETTLE = 2'b10
  } sw_state_e;

  // Configuration decode
  logic switch_ok;
  logic fail_safe_monitor;
  logic uses_pll;
  assign switch_ok         = ~SWITCH_MONITOR_CFG[1];          // R1
  assign fail_safe_monitor = (SWITCH_MONITOR_CFG == 2'h0);    // R2

  // Registers
  sw_state_e  st_q, st_d;
  logic [2:0] cur_q, cur_d;
  logic [2:0] req_q, req_d;
  logic       sw_q, sw_d;
  logic       frz_q, frz_d;
  logic       lock_q, lock_d;
  logic       fail_q, fail_d;
  logic       sdrv_q, sdrv_d;
  logic       sen_q, sen_d;
  logic       roi_q, roi_d;
  logic [2:0] ratio_q, ratio_d;
  logic       cpu_ratio_enable_q, cpu_ratio_enable_d;
  logic [2:0] post_q, post_d;
  logic [5:0] trim_q, trim_d;
  logic [3:0] settle_q, settle_d;
  logic [1:0] key_hi_q, key_hi_d;
  logic [1:0] key_lo_q, key_lo_d;
  logic       init_q;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;

  // APB decode, one wait state: answer in the cycle after the access phase
  logic acc, wr, rd;
  logic [15:0] wd;
  assign acc = PSEL & PENABLE & ~pready_q;
  assign wr  = acc & PWRITE;
  assign rd  = acc & ~PWRITE;
  assign wd  = PWDATA[15:0];

  logic hit_ctl, hit_div, hit_tun, hit_key;
  assign hit_ctl = (PADDR == OFS_OSC_CONTROL);
  assign hit_div = (PADDR == OFS_CLOCK_DIV);
  assign hit_tun = (PADDR == OFS_FAST_RC_TUNE);
  assign hit_key = (PADDR == OFS_UNLOCK_KEY);

  // Which sources run through the PLL
  assign uses_pll = (cur_q == SRC_PRIMARY_PL) || (cur_q == SRC_FRC_PLL);

  logic freeze_blocks;
  assign freeze_blocks = fail_safe_monitor & frz_q;  // R8 R9

  // Next-state for control register, switch sequencer and key tracking
  always_comb begin
    st_d     = st_q;
    cur_d    = cur_q;
    req_d    = req_q;
    sw_d     = sw_q;
    frz_d    = frz_q;
    lock_d   = lock_q;
    fail_d   = fail_q;
    sdrv_d   = sdrv_q;
    sen_d    = sen_q;
    roi_d    = roi_q;
    ratio_d  = ratio_q;
    cpu_ratio_enable_d  = cpu_ratio_enable_q;
    post_d   = post_q;
    trim_d   = trim_q;
    settle_d = settle_q;
    key_hi_d = key_hi_q;
    key_lo_d = key_lo_q;

    // Unlock keys must arrive back to back on the key register
    if (wr && hit_key) begin
      if (wd[15:8] == KEY_HI_FIRST)                              // R25
        key_hi_d = 2'h1;
      else if (wd[15:8] == KEY_HI_SECOND && key_hi_q == 2'h1)
        key_hi_d = 2'h2;
      else
        key_hi_d = 2'h0;
      if (wd[7:0] == KEY_LO_FIRST)
        key_lo_d = 2'h1;
      else if (wd[7:0] == KEY_LO_SECOND && key_lo_q == 2'h1)
        key_lo_d = 2'h2;
      else
        key_lo_d = 2'h0;
    end else if (wr) begin
      // Any other write consumes an open unlock window
      key_hi_d = 2'h0;
      key_lo_d = 2'h0;
    end

    if (wr && hit_ctl) begin
      if (key_hi_q == 2'h2)
        req_d = wd[REQ_SEL_LSB +: 3];                            // R6
      if (key_lo_q == 2'h2) begin
        frz_d  = frz_q | wd[FREEZE_BIT];                         // R8
        fail_d = fail_q & wd[FAIL_BIT];                          // R12
        sdrv_d = wd[SEC_DRIVE_BIT];                              // R13
        sen_d  = wd[SEC_ENABLE_BIT];                             // R14
        if (wd[SWITCH_BIT] && switch_ok && !freeze_blocks)       // R7 R27
          sw_d = 1'b1;
      end
    end
    if (wr && hit_div) begin
      roi_d   = wd[RECOVER_BIT];
      ratio_d = wd[RATIO_LSB +: 3];
      cpu_ratio_enable_d = wd[RATIO_EN_BIT];
      post_d  = wd[POSTSCALE_LSB +: 3];
    end
    if (wr && hit_tun)
      trim_d = wd[5:0];                                          // R20

    // Interrupt recovery wins over a same-cycle write
    if (IRQ_EVENT && roi_q)
      cpu_ratio_enable_d = 1'b0;                                            // R15

    // Hardware-set fail flag wins over software clear
    if (CLOCK_FAIL_DET && fail_safe_monitor)
      fail_d = 1'b1;                                             // R12

    // Lock tracking outside a switch
    if (st_q == SW_IDLE)
      lock_d = uses_pll & PLL_LOCKED;                            // R10 R11

    case (st_q)
      SW_IDLE: begin
        if (sw_q) begin
          if (req_q == cur_q) begin
            sw_d = 1'b0;                                         // R22
          end else begin
            lock_d   = 1'b0;                                     // R11
            fail_d   = CLOCK_FAIL_DET & fail_safe_monitor;
            settle_d = 4'h0;
            st_d     = SW_WAIT;
          end
        end
      end
      SW_WAIT: begin
        lock_d = 1'b0;
        if (NEW_SRC_READY &&
            (!(req_q == SRC_PRIMARY_PL || req_q == SRC_FRC_PLL) || PLL_LOCKED))
          st_d = SW_SETTLE;
      end
      SW_SETTLE: begin
        lock_d = (req_q == SRC_PRIMARY_PL || req_q == SRC_FRC_PLL) & PLL_LOCKED;
        if (NEW_SRC_TICK) begin
          if (settle_q == SETTLE_LAST) begin                     // R23
            cur_d = req_q;                                       // R24
            sw_d  = 1'b0;
            st_d  = SW_IDLE;
          end else begin
            settle_d = settle_q + 4'h1;
          end
        end
      end
      default: st_d = SW_IDLE;
    endcase

    // Switching disabled keeps request low and selection at configuration
    if (!switch_ok) begin
      sw_d  = 1'b0;                                              // R27 R1
      st_d  = SW_IDLE;
      cur_d = INITIAL_SOURCE_CFG;
    end
  end

  // Register read mux; unimplemented bits read zero
  always_comb begin
    prdata_d = 32'h0000_0000;                                    // R21
    if (rd && hit_ctl) begin
      prdata_d[CUR_SEL_LSB +: 3] = cur_q;                        // R5
      prdata_d[REQ_SEL_LSB +: 3] = req_q;
      prdata_d[FREEZE_BIT]       = frz_q;
      prdata_d[PLL_LOCK_BIT]     = lock_q;
      prdata_d[FAIL_BIT]         = fail_q;
      prdata_d[SEC_DRIVE_BIT]    = sdrv_q;
      prdata_d[SEC_ENABLE_BIT]   = sen_q;
      prdata_d[SWITCH_BIT]       = sw_q;
    end else if (rd && hit_div) begin
      prdata_d[RECOVER_BIT]        = roi_q;
      prdata_d[RATIO_LSB +: 3]     = ratio_q;                    // R16
      prdata_d[RATIO_EN_BIT]       = cpu_ratio_enable_q;
      prdata_d[POSTSCALE_LSB +: 3] = post_q;
    end else if (rd && hit_tun) begin
      prdata_d[5:0] = trim_q;
    end
    pready_d = acc;
  end

  // Requested source and current source load from straps after reset release
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_q     <= SW_IDLE;
      cur_q    <= SRC_FRC_DIV;                                   // R4
      req_q    <= SRC_FRC_DIV;
      sw_q     <= 1'b0;
      frz_q    <= 1'b0;
      lock_q   <= 1'b0;
      fail_q   <= 1'b0;
      sdrv_q   <= 1'b0;
      sen_q    <= 1'b0;
      roi_q    <= 1'b0;
      ratio_q  <= RATIO_RESET;                                   // R19
      cpu_ratio_enable_q  <= 1'b0;
      post_q   <= POSTSCALE_RESET;                               // R19
      trim_q   <= TRIM_RESET;
      settle_q <= 4'h0;
      key_hi_q <= 2'h0;
      key_lo_q <= 2'h0;
      init_q   <= 1'b1;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
    end else if (CLK_EN) begin
      if (init_q) begin
        // Strap capture after release, before any request can land
        cur_q  <= INITIAL_SOURCE_CFG;                            // R6
        req_q  <= INITIAL_SOURCE_CFG;
        init_q <= 1'b0;
      end else begin
        st_q   <= st_d;
        cur_q  <= cur_d;
        req_q  <= req_d;
      end
      sw_q     <= sw_d;
      frz_q    <= frz_d;
      lock_q   <= lock_d;
      fail_q   <= fail_d;
      sdrv_q   <= sdrv_d;
      sen_q    <= sen_d;
      roi_q    <= roi_d;
      ratio_q  <= ratio_d;
      cpu_ratio_enable_q  <= cpu_ratio_enable_d;
      post_q   <= post_d;
      trim_q   <= trim_d;
      settle_q <= settle_d;
      key_hi_q <= key_hi_d;
      key_lo_q <= key_lo_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
    end
  end

  // Divider masks: doze ratio, and postscale with the 256 step at code 111
  logic [7:0] doze_mask, post_mask;
  logic       doze_tick, post_tick;
  logic       post_used;
  assign doze_mask = cpu_ratio_enable_q ? 8'((9'h001 << ratio_q) - 9'h001) : 8'h00;  // R17 R16
  assign post_used = (cur_q == SRC_FRC_DIV) || (cur_q == SRC_LPFRC_DIV);
  assign post_mask = !post_used ? 8'h00 :
                     (post_q == 3'h7) ? 8'hFF :                  // R18
                     8'((9'h001 << post_q) - 9'h001);

  ratio_divider #(.CNT_W(8)) u_doze (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN & post_tick),
    .mask  (doze_mask),
    .tick  (doze_tick)
  );

  ratio_divider #(.CNT_W(8)) u_post (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .mask  (post_mask),
    .tick  (post_tick)
  );

  // Registered outputs
  // Drive request is meaningless for a digital clock input, so it is masked
  logic cpu_en_q, sys_en_q, drv_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cpu_en_q <= 1'b0;
      sys_en_q <= 1'b0;
      drv_q    <= 1'b0;
    end else if (CLK_EN) begin
      drv_q    <= sdrv_q & SECONDARY_SOURCE_CFG;                 // R13
      sys_en_q <= post_tick;
      cpu_en_q <= post_tick & (doze_tick | ~cpu_ratio_enable_q);            // R26 R17
    end
  end

  assign PRDATA               = prdata_q;
  assign PREADY               = pready_q;
  assign PSLVERR              = 1'b0;
  assign ACTIVE_SOURCE        = cur_q;
  assign TARGET_SOURCE        = req_q;
  assign SWITCH_BUSY          = sw_q;
  assign FAIL_SAFE_ON         = frz_q;
  assign SECONDARY_OSC_ENABLE = sen_q;                           // R14
  assign SECONDARY_DRIVE_HIGH = drv_q;                           // R13
  assign FAST_RC_TRIM         = trim_q;
  assign CPU_CLK_EN           = cpu_en_q;                        // R26
  assign SYS_CLK_EN           = sys_en_q;

  // Checks
  chk_redundant_abort: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CLK_EN && st_q == SW_IDLE && sw_q && req_q == cur_q && switch_ok && !init_q
    |=> !sw_q || !$stable(req_q))
    else $error("redundant switch not aborted"); // R22
  chk_no_switch_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !switch_ok && CLK_EN |=> !sw_q)
    else $error("switch request held while disabled"); // R27
  chk_lock_nonpll: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CLK_EN && st_q == SW_IDLE && !uses_pll |=> !lock_q)
    else $error("lock set in non-PLL mode"); // R11
  chk_fail_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CLK_EN && CLOCK_FAIL_DET && fail_safe_monitor |=> fail_q)
    else $error("fail flag not set"); // R12
  chk_recover_irq: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CLK_EN && IRQ_EVENT && roi_q |=> !cpu_ratio_enable_q)
    else $error("doze not cleared on interrupt"); // R15
  chk_freeze_stays: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    frz_q |=> frz_q)
    else $error("freeze bit cleared"); // R8
  chk_settle_done: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CLK_EN && st_q == SW_SETTLE && NEW_SRC_TICK && settle_q == SETTLE_LAST && switch_ok
    |=> cur_q == $past(req_q) && !sw_q)
    else $error("switch completion wrong"); // R24
  chk_key_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CLK_EN && !init_q && wr && hit_ctl && key_hi_q != 2'h2 |=> $stable(req_q))
    else $error("selection written without unlock"); // R25
endmodule
`default_nettype wire

// *** osc_ctrl_test.sv ***
// Self-checking testbench for the oscillator control block over APB
`timescale 1ns/1ns
`default_nettype none
module osc_ctrl_test
  import osc_ctrl_pkg::*;
;
  logic        SYS_CLK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1;
  logic [1:0]  SWITCH_MONITOR_CFG = 2'h0, PRIMARY_SUBMODE_CFG = 2'h3;
  logic [2:0]  INITIAL_SOURCE_CFG = 3'h7;
  logic        SECONDARY_SOURCE_CFG = 1'b1, NEW_SRC_READY = 1'b1, NEW_SRC_TICK = 1'b0;
  logic        PLL_LOCKED = 1'b1, CLOCK_FAIL_DET = 1'b0, IRQ_EVENT = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rdata;
  logic [2:0]  ACTIVE_SOURCE, TARGET_SOURCE;
  logic        SWITCH_BUSY, FAIL_SAFE_ON, SECONDARY_OSC_ENABLE, SECONDARY_DRIVE_HIGH;
  logic [5:0]  FAST_RC_TRIM;
  logic        CPU_CLK_EN, SYS_CLK_EN;
  int          errors = 0, check_count = 0, busy_ticks = 0, cpu_n, sys_n, d;

  osc_ctrl u_osc_ctrl (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
    .SWITCH_MONITOR_CFG(SWITCH_MONITOR_CFG), .PRIMARY_SUBMODE_CFG(PRIMARY_SUBMODE_CFG),
    .INITIAL_SOURCE_CFG(INITIAL_SOURCE_CFG), .SECONDARY_SOURCE_CFG(SECONDARY_SOURCE_CFG),
    .NEW_SRC_READY(NEW_SRC_READY), .NEW_SRC_TICK(NEW_SRC_TICK), .PLL_LOCKED(PLL_LOCKED),
    .CLOCK_FAIL_DET(CLOCK_FAIL_DET), .IRQ_EVENT(IRQ_EVENT), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .ACTIVE_SOURCE(ACTIVE_SOURCE), .TARGET_SOURCE(TARGET_SOURCE),
    .SWITCH_BUSY(SWITCH_BUSY), .FAIL_SAFE_ON(FAIL_SAFE_ON),
    .SECONDARY_OSC_ENABLE(SECONDARY_OSC_ENABLE), .SECONDARY_DRIVE_HIGH(SECONDARY_DRIVE_HIGH),
    .FAST_RC_TRIM(FAST_RC_TRIM), .CPU_CLK_EN(CPU_CLK_EN), .SYS_CLK_EN(SYS_CLK_EN));

  // Clock, and a new-source tick every other cycle
  always #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) NEW_SRC_TICK <= ~NEW_SRC_TICK;
  // Settle ticks seen while a switch is pending
  always @(posedge SYS_CLK) if (SWITCH_BUSY === 1'b1 && NEW_SRC_TICK === 1'b1) busy_ticks++;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; held until PREADY is sampled high, bounded
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rdata = PRDATA;
    chk("slave error", 32'h0, {31'h0, PSLVERR});
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdata);
  endtask

  // Opens both control bytes, then writes the control register
  task automatic ctl(input logic [15:0] v);
    apb(1'b1, OFS_UNLOCK_KEY, {16'h0, KEY_HI_FIRST, KEY_LO_FIRST});
    apb(1'b1, OFS_UNLOCK_KEY, {16'h0, KEY_HI_SECOND, KEY_LO_SECOND});
    apb(1'b1, OFS_OSC_CONTROL, {16'h0, v});
  endtask

  // Full switch; waits on the busy flag under a bound
  task automatic switch_to(input logic [2:0] s, input logic [7:0] lo);
    int n;
    n = 0;
    ctl({5'h0, s, lo});
    busy_ticks = 0;
    ctl({5'h0, s, lo | 8'h01});
    while (SWITCH_BUSY !== 1'b0 && n < 500) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("switch done", 32'h0, {31'h0, SWITCH_BUSY});
  endtask

  task automatic measure(input int cyc);
    cpu_n = 0; sys_n = 0;
    repeat (cyc) begin
      @(posedge SYS_CLK);
      cpu_n += (CPU_CLK_EN === 1'b1);
      sys_n += (SYS_CLK_EN === 1'b1);
    end
  endtask

  task automatic pulse_irq();
    @(posedge SYS_CLK) IRQ_EVENT <= 1'b1;
    @(posedge SYS_CLK) IRQ_EVENT <= 1'b0;
  endtask

  task automatic restart(input logic [1:0] cfg, input logic [2:0] init);
    @(posedge SYS_CLK);
    SWITCH_MONITOR_CFG <= cfg; INITIAL_SOURCE_CFG <= init; RST_N <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the expected run of about 17k cycles
  initial begin
    repeat (60000) @(posedge SYS_CLK);
    errors++;
    print_verdict();
  end

  initial begin
    restart(2'h0, 3'h7);
    rd_chk("control reset", OFS_OSC_CONTROL, 32'h7700);
    rd_chk("divider reset", OFS_CLOCK_DIV, 32'h3100);
    rd_chk("tune reset", OFS_FAST_RC_TUNE, 32'h0);
    rd_chk("unmapped", 12'h010, 32'h0);
    apb(1'b1, OFS_FAST_RC_TUNE, 32'hFFFF_FFFF);
    rd_chk("tune all ones", OFS_FAST_RC_TUNE, 32'h003F);
    chk("trim out", 32'h3F, {26'h0, FAST_RC_TRIM});
    apb(1'b1, OFS_CLOCK_DIV, 32'hFFFF_FFFF);
    rd_chk("divider all ones", OFS_CLOCK_DIV, 32'hFF00);
    apb(1'b1, OFS_OSC_CONTROL, 32'h0000_0201);
    rd_chk("locked control", OFS_OSC_CONTROL, 32'h7700);
    // Every doze ratio and every postscale code in turn
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_CLOCK_DIV, {16'h0, 1'b0, 3'(i), 1'b1, 3'h0, 8'h00});
      measure(1024);
      d = cpu_n * (1 << i) - sys_n;
      chk("doze ratio", 32'h1, {31'h0, d <= 2 * (1 << i) && d >= -2 * (1 << i)});
      apb(1'b1, OFS_CLOCK_DIV, {16'h0, 1'b0, 3'h7, 1'b0, 3'(i), 8'h00});
      measure(1024);
      d = cpu_n - 1024 / ((i == 7) ? 256 : (1 << i));
      chk("postscale", 32'h1, {31'h0, d <= 1 && d >= -1});
    end
    apb(1'b1, OFS_CLOCK_DIV, 32'h0000_B800);
    pulse_irq();
    rd_chk("recover on irq", OFS_CLOCK_DIV, 32'hB000);
    apb(1'b1, OFS_CLOCK_DIV, 32'h0000_3800);
    pulse_irq();
    rd_chk("no recover", OFS_CLOCK_DIV, 32'h3800);
    // Enable low freezes state: a failure seen then is not recorded
    @(posedge SYS_CLK) CLK_EN <= 1'b0;
    @(posedge SYS_CLK) CLOCK_FAIL_DET <= 1'b1;
    @(posedge SYS_CLK) CLOCK_FAIL_DET <= 1'b0;
    @(posedge SYS_CLK) CLK_EN <= 1'b1;
    rd_chk("frozen fail", OFS_OSC_CONTROL, 32'h7700);
    // Fail flag: set by the monitor, cleared by software
    @(posedge SYS_CLK) CLOCK_FAIL_DET <= 1'b1;
    @(posedge SYS_CLK) CLOCK_FAIL_DET <= 1'b0;
    rd_chk("fail set", OFS_OSC_CONTROL, 32'h7708);
    ctl(16'h0700);
    rd_chk("fail cleared", OFS_OSC_CONTROL, 32'h7700);
    switch_to(SRC_FRC, 8'h06);
    chk("settle", 32'h1, {31'h0, busy_ticks >= SETTLE_CYCLES && busy_ticks <= SETTLE_CYCLES + 2});
    rd_chk("after switch", OFS_OSC_CONTROL, 32'h0006);
    chk("sec enable", 32'h1, {31'h0, SECONDARY_OSC_ENABLE});
    chk("sec drive", 32'h1, {31'h0, SECONDARY_DRIVE_HIGH});
    switch_to(SRC_FRC_PLL, 8'h00);
    rd_chk("pll switch", OFS_OSC_CONTROL, 32'h1120);
    switch_to(SRC_FRC_PLL, 8'h00);
    chk("redundant", 32'h1, {31'h0, busy_ticks < SETTLE_CYCLES});
    chk("redundant src", 32'h1, {29'h0, ACTIVE_SOURCE});
    // Freeze with monitor on blocks later requests
    ctl(16'h0180);
    chk("freeze", 32'h1, {31'h0, FAIL_SAFE_ON});
    ctl(16'h0280);
    ctl(16'h0281);
    repeat (60) @(posedge SYS_CLK);
    chk("frozen src", 32'h1, {29'h0, ACTIVE_SOURCE});
    // Monitor off: freeze has no hold, fail flag never set
    restart(2'h1, 3'h7);
    ctl(16'h0780);
    @(posedge SYS_CLK) CLOCK_FAIL_DET <= 1'b1;
    @(posedge SYS_CLK) CLOCK_FAIL_DET <= 1'b0;
    switch_to(SRC_PRIMARY, 8'h80);
    rd_chk("unfrozen", OFS_OSC_CONTROL, 32'h2280);
    // Switching disabled by configuration, secondary fed a digital clock
    @(posedge SYS_CLK) SECONDARY_SOURCE_CFG <= 1'b0;
    restart(2'h2, 3'h5);
    rd_chk("init low_power_rc_source", OFS_OSC_CONTROL, 32'h5500);
    chk("target init", 32'h5, {29'h0, TARGET_SOURCE});
    ctl(16'h0000);
    ctl(16'h0005);
    chk("digital drive", 32'h0, {31'h0, SECONDARY_DRIVE_HIGH});
    repeat (30) @(posedge SYS_CLK);
    chk("no switch src", 32'h5, {29'h0, ACTIVE_SOURCE});
    chk("request held", 32'h0, {31'h0, SWITCH_BUSY});
    print_verdict();
  end
endmodule
`default_nettype wire
